//--- serial_pkg.sv
package serial_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [15:0] serial_mode_control_addr = 16'hff70;
   localparam logic [15:0] baud_generator_addr      = 16'hff71;
   localparam logic [15:0] transmit_shift_addr      = 16'hff72;
   localparam logic [15:0] receive_buffer_addr      = 16'hff72;
   localparam logic [15:0] receive_error_addr       = 16'hff73;
   localparam logic [15:0] port1_direction_addr     = 16'hff21;
   localparam logic [15:0] port1_latch_addr         = 16'hff01;

   localparam logic [7:0] serial_mode_reset     = 8'h01;
   localparam logic [7:0] baud_generator_reset  = 8'h1f;
   localparam logic [7:0] port1_direction_reset = 8'hff;
   localparam logic [7:0] port1_latch_reset     = 8'h00;

   // ----------------------------------------------------------------
   // Mode register fields
   // ----------------------------------------------------------------
   localparam int unit_power_enable_pos   = 7;
   localparam int transmit_enable_bit_pos = 6;
   localparam int receive_enable_bit_pos  = 5;
   localparam int parity_select_high_pos  = 4;
   localparam int parity_select_low_pos   = 3;
   localparam int char_length_select_pos  = 2;
   localparam int stop_length_select_pos  = 1;

   localparam int parity_error_pos  = 2;
   localparam int framing_error_pos = 1;
   localparam int overrun_error_pos = 0;

   localparam int tx_pin_index = 0;
   localparam int rx_pin_index = 1;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam logic [4:0] divider_min = 5'h08;

   typedef enum logic [1:0]
   {
      parity_none = 2'h0,
      parity_zero = 2'h1,
      parity_odd  = 2'h2,
      parity_even = 2'h3
   } parity_mode_t;

   typedef struct packed
   {
      logic         power;
      logic         tx_enable;
      logic         rx_enable;
      parity_mode_t parity;
      logic         eight_bits;
      logic         two_stops;
   } frame_cfg_t;

   typedef struct packed
   {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } reg_req_t;

endpackage : serial_pkg

//--- serial_tick.sv
`timescale 1ns/10ps
`default_nettype none

// Half-bit tick generator; a bit lasts two ticks.
module serial_tick
(
   input  wire logic       clk_sys,
   input  wire logic       clear,
   input  wire logic [4:0] divide,
   output logic            tick
);

   logic [4:0] count_ff;
   logic [4:0] nxt_count;

   always_comb
   begin
      nxt_count = count_ff + 5'h01;
      tick      = 1'b0;
      if (clear)
      begin
         nxt_count = 5'h00;
      end
      else if (count_ff >= divide - 5'h01)
      begin
         nxt_count = 5'h00;
         tick      = 1'b1;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      count_ff <= nxt_count;
   end

endmodule : serial_tick

`default_nettype wire

//--- serial_sync.sv
`timescale 1ns/10ps
`default_nettype none

// Three-stage pin synchroniser; output moves when stages two and three agree.
module serial_sync
(
   input  wire logic clk_sys,
   input  wire logic srst,
   input  wire logic pin,
   output logic      level
);

   logic [2:0] stage_ff;
   logic       level_ff;
   logic [2:0] nxt_stage;
   logic       nxt_level;

   always_comb
   begin
      nxt_stage = {stage_ff[1:0], pin};
      nxt_level = level_ff;
      if (stage_ff[1] == stage_ff[2])
      begin
         nxt_level = stage_ff[2];
      end
      if (srst)
      begin
         nxt_stage = 3'h7;
         nxt_level = 1'b1;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      stage_ff <= nxt_stage;
      level_ff <= nxt_level;
   end

   assign level = level_ff;

endmodule : serial_sync

`default_nettype wire

//--- async_serial_unit.sv
`timescale 1ns/10ps
`default_nettype none

module async_serial_unit
(
   input  wire logic                clk_sys,
   input  wire logic                srst,
   input  wire serial_pkg::reg_req_t req,
   output logic [7:0]               rdata,
   input  wire logic [7:0]          port1_pin_in,
   output logic [7:0]               port1_pin_out,
   output logic [7:0]               port1_pin_oe,
   output logic                     transmit_done_irq,
   output logic                     receive_done_irq,
   output logic                     receive_error_irq
);

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [7:0] mode_ff, nxt_mode;
   logic [7:0] baud_ff, nxt_baud;
   logic [7:0] dir_ff, nxt_dir;
   logic [7:0] latch_ff, nxt_latch;
   logic [7:0] rdata_ff, nxt_rdata;
   serial_pkg::frame_cfg_t cfg;

   assign cfg.power      = mode_ff[serial_pkg::unit_power_enable_pos];
   assign cfg.tx_enable  = mode_ff[serial_pkg::transmit_enable_bit_pos];
   assign cfg.rx_enable  = mode_ff[serial_pkg::receive_enable_bit_pos];
   assign cfg.parity     = serial_pkg::parity_mode_t'({mode_ff[serial_pkg::parity_select_high_pos],
                                                      mode_ff[serial_pkg::parity_select_low_pos]});
   assign cfg.eight_bits = mode_ff[serial_pkg::char_length_select_pos];
   assign cfg.two_stops  = mode_ff[serial_pkg::stop_length_select_pos];

   logic tx_run, rx_run;
   assign tx_run = cfg.power & cfg.tx_enable;
   assign rx_run = cfg.power & cfg.rx_enable;

   // ----------------------------------------------------------------
   // Pins
   // ----------------------------------------------------------------
   logic tx_line_ff;
   logic rx_sync;
   logic rx_level;

   serial_sync u_rx_sync
   (
      .clk_sys (clk_sys),
      .srst    (srst),
      .pin     (port1_pin_in[serial_pkg::rx_pin_index]),
      .level   (rx_sync)
   );

   assign rx_level = cfg.power ? rx_sync : 1'b1;

   always_comb
   begin
      port1_pin_out = latch_ff;
      port1_pin_oe  = ~dir_ff;
      if (tx_run)
      begin
         port1_pin_out[serial_pkg::tx_pin_index] = latch_ff[serial_pkg::tx_pin_index] & tx_line_ff;
      end
   end

   // ----------------------------------------------------------------
   // Transmitter
   // ----------------------------------------------------------------
   typedef enum logic [3:0]
   {
      tx_idle  = 4'b0001,
      tx_start = 4'b0010,
      tx_data  = 4'b0100,
      tx_stop  = 4'b1000
   } tx_state_t;

   tx_state_t  tx_state_ff, nxt_tx_state;
   logic [8:0] tx_shift_ff, nxt_tx_shift;
   logic [3:0] tx_bits_ff, nxt_tx_bits;
   logic       tx_half_ff, nxt_tx_half;
   logic       nxt_tx_line, nxt_tx_done;
   logic       tx_done_ff;
   logic       tx_tick, rx_tick;
   logic       tx_write;
   logic       tx_parity;
   logic [7:0] tx_mask;

   assign tx_write  = req.wr && req.addr == serial_pkg::transmit_shift_addr;
   assign tx_mask   = cfg.eight_bits ? 8'hff : 8'h7f;
   assign tx_parity = (cfg.parity == serial_pkg::parity_even) ? ^(req.wdata & tx_mask)
                    : (cfg.parity == serial_pkg::parity_odd)  ? ~^(req.wdata & tx_mask)
                    : 1'b0;

   serial_tick u_tx_tick
   (
      .clk_sys (clk_sys),
      .clear   (srst | ~tx_run | (tx_write & (tx_state_ff == tx_idle))),
      .divide  (baud_ff[4:0] < serial_pkg::divider_min ? serial_pkg::divider_min : baud_ff[4:0]),
      .tick    (tx_tick)
   );

   always_comb
   begin
      nxt_tx_state = tx_state_ff;
      nxt_tx_shift = tx_shift_ff;
      nxt_tx_bits  = tx_bits_ff;
      nxt_tx_half  = tx_half_ff;
      nxt_tx_line  = tx_line_ff;
      nxt_tx_done  = 1'b0;
      unique case (tx_state_ff)
         tx_idle:
         begin
            nxt_tx_line = 1'b1;
            if (tx_write)
            begin
               nxt_tx_shift = cfg.eight_bits ? {tx_parity, req.wdata} : {1'b1, tx_parity, req.wdata[6:0]};
               nxt_tx_bits  = 4'(7 + (cfg.eight_bits ? 1 : 0) + (cfg.parity != serial_pkg::parity_none ? 1 : 0));
               nxt_tx_state = tx_start;
               nxt_tx_half  = 1'b0;
               nxt_tx_line  = 1'b0;
            end
         end
         tx_start:
         begin
            if (tx_tick)
            begin
               nxt_tx_half = ~tx_half_ff;
               if (tx_half_ff)
               begin
                  nxt_tx_state = tx_data;
                  nxt_tx_line  = tx_shift_ff[0];
               end
            end
         end
         tx_data:
         begin
            if (tx_tick)
            begin
               nxt_tx_half = ~tx_half_ff;
               if (tx_half_ff)
               begin
                  nxt_tx_shift = {1'b1, tx_shift_ff[8:1]};
                  nxt_tx_bits  = tx_bits_ff - 4'h1;
                  if (tx_bits_ff == 4'h1)
                  begin
                     nxt_tx_state = tx_stop;
                     nxt_tx_line  = 1'b1;
                     nxt_tx_bits  = cfg.two_stops ? 4'h2 : 4'h1;
                  end
                  else
                  begin
                     nxt_tx_line = tx_shift_ff[1];
                  end
               end
            end
         end
         tx_stop:
         begin
            if (tx_tick)
            begin
               nxt_tx_half = ~tx_half_ff;
               if (tx_half_ff)
               begin
                  nxt_tx_bits = tx_bits_ff - 4'h1;
                  if (tx_bits_ff == 4'h1)
                  begin
                     nxt_tx_state = tx_idle;
                     nxt_tx_done  = 1'b1;
                  end
               end
            end
         end
      endcase
      if (srst || !tx_run)
      begin
         nxt_tx_done  = 1'b0;
         nxt_tx_state = tx_idle;
         nxt_tx_shift = 9'h000;
         nxt_tx_bits  = 4'h0;
         nxt_tx_half  = 1'b0;
         nxt_tx_line  = 1'b1;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      tx_state_ff <= nxt_tx_state;
      tx_shift_ff <= nxt_tx_shift;
      tx_bits_ff  <= nxt_tx_bits;
      tx_half_ff  <= nxt_tx_half;
      tx_line_ff  <= nxt_tx_line;
      tx_done_ff  <= nxt_tx_done;
   end

   assign transmit_done_irq = tx_done_ff;

   // ----------------------------------------------------------------
   // Receiver, runs alongside the transmitter
   // ----------------------------------------------------------------
   typedef enum logic [2:0]
   {
      rx_idle  = 3'b001,
      rx_start = 3'b010,
      rx_data  = 3'b100
   } rx_state_t;

   rx_state_t  rx_state_ff, nxt_rx_state;
   logic [8:0] rx_shift_ff, nxt_rx_shift;
   logic [3:0] rx_bits_ff, nxt_rx_bits;
   logic       rx_half_ff, nxt_rx_half;
   logic [7:0] rx_buf_ff, nxt_rx_buf;
   logic       rx_full_ff, nxt_rx_full;
   logic [2:0] err_ff, nxt_err;
   logic       rx_done_ff, nxt_rx_done;
   logic       rx_errirq_ff, nxt_rx_errirq;
   logic [3:0] rx_total;
   logic [7:0] rx_word;
   logic       rx_par_bad;

   serial_tick u_rx_tick
   (
      .clk_sys (clk_sys),
      .clear   (srst | ~rx_run | rx_state_ff == rx_idle),
      .divide  (baud_ff[4:0] < serial_pkg::divider_min ? serial_pkg::divider_min : baud_ff[4:0]),
      .tick    (rx_tick)
   );

   assign rx_total = 4'(7 + (cfg.eight_bits ? 1 : 0) + (cfg.parity != serial_pkg::parity_none ? 1 : 0));

   always_comb
   begin
      rx_word    = 8'h00;
      rx_par_bad = 1'b0;
      if (cfg.parity == serial_pkg::parity_none)
      begin
         rx_word = cfg.eight_bits ? rx_shift_ff[8:1] : {1'b0, rx_shift_ff[8:2]};
      end
      else
      begin
         rx_word = cfg.eight_bits ? rx_shift_ff[7:0] : {1'b0, rx_shift_ff[7:1]};
         if (cfg.parity == serial_pkg::parity_even)
            rx_par_bad = ^{rx_word, rx_shift_ff[8]};
         else if (cfg.parity == serial_pkg::parity_odd)
            rx_par_bad = ~^{rx_word, rx_shift_ff[8]};
      end
   end

   always_comb
   begin
      nxt_rx_state  = rx_state_ff;
      nxt_rx_shift  = rx_shift_ff;
      nxt_rx_bits   = rx_bits_ff;
      nxt_rx_half   = rx_half_ff;
      nxt_rx_buf    = rx_buf_ff;
      nxt_rx_full   = rx_full_ff;
      nxt_err       = err_ff;
      nxt_rx_done   = 1'b0;
      nxt_rx_errirq = 1'b0;
      if (req.rd && req.addr == serial_pkg::receive_error_addr)
         nxt_err = 3'h0;
      if (req.rd && req.addr == serial_pkg::receive_buffer_addr)
         nxt_rx_full = 1'b0;
      unique case (rx_state_ff)
         rx_idle:
         begin
            if (!rx_level)
            begin
               nxt_rx_state = rx_start;
               nxt_rx_half  = 1'b0;
            end
         end
         rx_start:
         begin
            if (rx_tick)
            begin
               if (rx_level)
                  nxt_rx_state = rx_idle;
               else
               begin
                  nxt_rx_state = rx_data;
                  nxt_rx_bits  = 4'h0;
                  nxt_rx_half  = 1'b0;
               end
            end
         end
         rx_data:
         begin
            if (rx_tick)
            begin
               nxt_rx_half = ~rx_half_ff;
               if (rx_half_ff)
               begin
                  if (rx_bits_ff == rx_total)
                  begin
                     nxt_rx_state = rx_idle;
                     nxt_rx_done  = 1'b1;
                     // Error flags set here win over a same-cycle status read.
                     nxt_err[serial_pkg::parity_error_pos]  = err_ff[serial_pkg::parity_error_pos] | rx_par_bad;
                     nxt_err[serial_pkg::framing_error_pos] = err_ff[serial_pkg::framing_error_pos] | ~rx_level;
                     nxt_rx_errirq = rx_par_bad | ~rx_level | rx_full_ff;
                     if (rx_full_ff && !(req.rd && req.addr == serial_pkg::receive_buffer_addr))
                        nxt_err[serial_pkg::overrun_error_pos] = 1'b1;
                     else
                     begin
                        nxt_rx_buf  = rx_word;
                        nxt_rx_full = 1'b1;
                     end
                  end
                  else
                  begin
                     nxt_rx_shift = {rx_level, rx_shift_ff[8:1]};
                     nxt_rx_bits  = rx_bits_ff + 4'h1;
                  end
               end
            end
         end
      endcase
      if (srst || !rx_run)
      begin
         nxt_rx_done   = 1'b0;
         nxt_rx_errirq = 1'b0;
         nxt_rx_state = rx_idle;
         nxt_rx_shift = 9'h000;
         nxt_rx_bits  = 4'h0;
         nxt_rx_half  = 1'b0;
         nxt_rx_full  = 1'b0;
         nxt_err      = 3'h0;
      end
      if (srst || !cfg.power)
         nxt_rx_buf = 8'hff;
   end

   always_ff @(posedge clk_sys)
   begin
      rx_state_ff  <= nxt_rx_state;
      rx_shift_ff  <= nxt_rx_shift;
      rx_bits_ff   <= nxt_rx_bits;
      rx_half_ff   <= nxt_rx_half;
      rx_buf_ff    <= nxt_rx_buf;
      rx_full_ff   <= nxt_rx_full;
      err_ff       <= nxt_err;
      rx_done_ff   <= nxt_rx_done;
      rx_errirq_ff <= nxt_rx_errirq;
   end

   assign receive_done_irq  = rx_done_ff;
   assign receive_error_irq = rx_errirq_ff;

   // ----------------------------------------------------------------
   // Register access
   // ----------------------------------------------------------------
   always_comb
   begin
      nxt_mode  = mode_ff;
      nxt_baud  = baud_ff;
      nxt_dir   = dir_ff;
      nxt_latch = latch_ff;
      nxt_rdata = rdata_ff;
      if (req.wr)
      begin
         unique case (req.addr)
            serial_pkg::serial_mode_control_addr: nxt_mode  = {req.wdata[7:1], 1'b1};
            serial_pkg::baud_generator_addr:      nxt_baud  = req.wdata;
            serial_pkg::port1_direction_addr:     nxt_dir   = req.wdata;
            serial_pkg::port1_latch_addr:         nxt_latch = req.wdata;
            default:                              nxt_mode  = mode_ff;
         endcase
      end
      if (req.rd)
      begin
         unique case (req.addr)
            serial_pkg::serial_mode_control_addr: nxt_rdata = mode_ff;
            serial_pkg::baud_generator_addr:      nxt_rdata = baud_ff;
            serial_pkg::receive_buffer_addr:      nxt_rdata = rx_buf_ff;
            serial_pkg::receive_error_addr:       nxt_rdata = {5'h00, err_ff};
            serial_pkg::port1_direction_addr:     nxt_rdata = dir_ff;
            serial_pkg::port1_latch_addr:         nxt_rdata = latch_ff;
            default:                              nxt_rdata = 8'h00;
         endcase
      end
      if (srst)
      begin
         nxt_mode  = serial_pkg::serial_mode_reset;
         nxt_baud  = serial_pkg::baud_generator_reset;
         nxt_dir   = serial_pkg::port1_direction_reset;
         nxt_latch = serial_pkg::port1_latch_reset;
         nxt_rdata = 8'h00;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      mode_ff  <= nxt_mode;
      baud_ff  <= nxt_baud;
      dir_ff   <= nxt_dir;
      latch_ff <= nxt_latch;
      rdata_ff <= nxt_rdata;
   end

   assign rdata = rdata_ff;

endmodule : async_serial_unit

`default_nettype wire

//--- async_serial_unit_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module async_serial_unit_checker
(
   input wire logic                 clk_sys,
   input wire logic                 srst,
   input wire serial_pkg::reg_req_t req,
   input wire logic [7:0]           rdata,
   input wire logic [7:0]           port1_pin_in,
   input wire logic [7:0]           port1_pin_out,
   input wire logic [7:0]           port1_pin_oe,
   input wire logic                 transmit_done_irq,
   input wire logic                 receive_done_irq,
   input wire logic                 receive_error_irq
);
   // --------------------
   // Register shadows
   // --------------------
   logic [7:0] mode_ff, dir_ff, latch_ff, nxt_mode, nxt_dir, nxt_latch;
   logic       busy_ff, nxt_busy, tx_go;
   assign tx_go = req.wr && req.addr == serial_pkg::transmit_shift_addr && mode_ff[7] && mode_ff[6] && !busy_ff;
   always_comb
   begin
      nxt_mode = mode_ff;
      nxt_dir = dir_ff;
      nxt_latch = latch_ff;
      nxt_busy = busy_ff && mode_ff[7] && mode_ff[6] && !transmit_done_irq;
      if (req.wr && req.addr == serial_pkg::serial_mode_control_addr)
         nxt_mode = req.wdata | 8'h01;
      if (req.wr && req.addr == serial_pkg::port1_direction_addr)
         nxt_dir = req.wdata;
      if (req.wr && req.addr == serial_pkg::port1_latch_addr)
         nxt_latch = req.wdata;
      if (tx_go)
         nxt_busy = 1'b1;
   end
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         mode_ff <= 8'h01;
         dir_ff <= 8'hff;
         latch_ff <= 8'h00;
         busy_ff <= 1'b0;
      end
      else
      begin
         mode_ff <= nxt_mode;
         dir_ff <= nxt_dir;
         latch_ff <= nxt_latch;
         busy_ff <= nxt_busy;
      end
   end
   // --------------------
   // Properties
   // --------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   sequence s_tx_accept;
      tx_go && latch_ff[0];
   endsequence
   sequence s_start_bit;
      (!port1_pin_out[0]) [*8];
   endsequence
   AST_START_BIT: assert property (s_tx_accept |=> s_start_bit)
      else $error("start bit missing after transmit write");
   AST_OE_DIR: assert property ($stable(dir_ff) |-> port1_pin_oe == ~dir_ff)
      else $error("output enable differs from direction");
   AST_UPPER_PINS: assert property ($stable(latch_ff) |-> port1_pin_out[7:1] == latch_ff[7:1])
      else $error("port pins differ from latch");
   AST_STOP_MODE: assert property (!mode_ff[7] && !$past(mode_ff[7]) && $stable(latch_ff)
      |-> port1_pin_out[0] == latch_ff[0])
      else $error("transmit pin not returned to port use");
   AST_DONE_PULSE: assert property (transmit_done_irq |=> !transmit_done_irq)
      else $error("transmit done longer than one cycle");
   AST_DONE_AFTER_FRAME: assert property (transmit_done_irq |-> busy_ff)
      else $error("transmit done without a frame");
   AST_ERR_WITH_DONE: assert property (receive_error_irq |-> receive_done_irq)
      else $error("receive error outside completion");
   AST_NO_RX_OFF: assert property (!mode_ff[5] && !$past(mode_ff[5]) |-> !receive_done_irq)
      else $error("reception while disabled");
   AST_NO_TX_OFF: assert property (!mode_ff[6] && !$past(mode_ff[6]) |-> !transmit_done_irq)
      else $error("transmission while disabled");
   AST_BUF_OFF: assert property (req.rd && req.addr == serial_pkg::receive_buffer_addr && !mode_ff[7]
      && !$past(mode_ff[7]) |=> rdata == 8'hff)
      else $error("receive buffer not cleared by power off");
endmodule : async_serial_unit_checker
bind async_serial_unit async_serial_unit_checker chk
(
   .clk_sys(clk_sys),
   .srst(srst),
   .req(req),
   .rdata(rdata),
   .port1_pin_in(port1_pin_in),
   .port1_pin_out(port1_pin_out),
   .port1_pin_oe(port1_pin_oe),
   .transmit_done_irq(transmit_done_irq),
   .receive_done_irq(receive_done_irq),
   .receive_error_irq(receive_error_irq)
);
`default_nettype wire

//--- serial_peer.sv
`timescale 1ns/10ps
`default_nettype none
module serial_peer
(
   input wire logic clk_sys,
   input wire logic line_in,
   output var logic line_out
);
   initial line_out = 1'b1;
   task automatic send(input logic [11:0] bits, input int n, input int cyc);
      for (int i = 0; i < n * cyc; i++)
      begin
         @(posedge clk_sys);
         #1 line_out = bits[i / cyc];
      end
      @(posedge clk_sys);
      #1 line_out = 1'b1;
   endtask : send
   // Sampling on the falling edge keeps clear of the sender's own edge.
   task automatic grab(input int n, input int cyc, output logic [11:0] bits);
      int t;
      bits = '1;
      for (t = 0; t < 4000 && line_in; t++)
         @(negedge clk_sys);
      if (line_in)
         bits = 'x;
      repeat (cyc / 2) @(negedge clk_sys);
      for (int i = 0; i < n; i++)
      begin
         bits[i] = line_in;
         repeat (cyc) @(negedge clk_sys);
      end
   endtask : grab
endmodule : serial_peer
`default_nettype wire

//--- async_serial_mode_parity_tb.sv
`timescale 1ns/10ps
`default_nettype none
module async_serial_mode_parity_tb;
   logic                 clk_sys = 1'b0;
   logic                 srst = 1'b1;
   serial_pkg::reg_req_t req = '0;
   logic [7:0]           rdata, pin_in, pin_out, pin_oe;
   logic                 tx_done, rx_done, rx_err, tx_line, peer_line;
   logic [7:0]           tx_data [4] = '{8'h55, 8'h36, 8'h86, 8'h2c};
   int                   n_errors = 0;
   int                   n_compared = 0;
   int                   n_done = 0;
   always #10 clk_sys = ~clk_sys;
   // The transmit pin has a pull-up, so it reads high while nobody drives it.
   assign tx_line = pin_oe[0] ? pin_out[0] : 1'b1;
   assign pin_in = {6'h15, peer_line, tx_line};
   always @(posedge clk_sys)
      if (tx_done === 1'b1)
         n_done++;
   async_serial_unit dut (.clk_sys(clk_sys), .srst(srst), .req(req), .rdata(rdata), .port1_pin_in(pin_in),
      .port1_pin_out(pin_out), .port1_pin_oe(pin_oe), .transmit_done_irq(tx_done),
      .receive_done_irq(rx_done), .receive_error_irq(rx_err));
   serial_peer peer (.clk_sys(clk_sys), .line_in(tx_line), .line_out(peer_line));
   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_sys);
      #1 req = '0;
   endtask : wr
   task automatic rdc(input logic [15:0] a, input logic [7:0] exp, input logic [7:0] mask = 8'hff);
      @(posedge clk_sys);
      #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk_sys);
      #1 req = '0;
      chk({4'h0, rdata & mask}, {4'h0, exp & mask});
   endtask : rdc
   function automatic logic [11:0] frame(input logic [7:0] d, input int pm, input logic eight, input logic two,
      input logic flip, output int n);
      logic p;
      p = (^(d & (eight ? 8'hff : 8'h7f))) ^ (pm == 2) ^ flip;
      if (pm == 1)
         p = flip;
      n = (eight ? 10 : 9) + int'(pm != 0) + int'(two);
      if (pm == 0)
         return eight ? {3'b111, d, 1'b0} : {4'hf, d[6:0], 1'b0};
      return eight ? {2'b11, p, d, 1'b0} : {3'b111, p, d[6:0], 1'b0};
   endfunction : frame
   task automatic wrap_up;
      if (n_errors == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up
   initial
   begin
      logic [11:0] got, txf, rxf;
      logic [7:0]  fmt;
      int          nt, nr;
      repeat (16) @(posedge clk_sys);
      #1 srst = 1'b0;
      rdc(serial_pkg::serial_mode_control_addr, 8'h01);
      rdc(serial_pkg::baud_generator_addr, 8'h1f);
      rdc(serial_pkg::port1_direction_addr, 8'hff);
      rdc(serial_pkg::receive_error_addr, 8'h00);
      rdc(16'h1234, 8'h00);
      chk({4'h0, pin_oe}, 12'h000);
      wr(serial_pkg::baud_generator_addr, 8'h08);
      wr(serial_pkg::port1_latch_addr, 8'h01);
      wr(serial_pkg::port1_direction_addr, 8'hfe);
      chk({4'h0, pin_oe}, 12'h001);
      // Each pass sets a new parity mode and length (two stop bits from the third pass on), then runs both directions at once.
      for (int m = 0; m < 4; m++)
      begin
         fmt = {3'b000, 2'(m), ~m[0], m[1], 1'b1};
         wr(serial_pkg::serial_mode_control_addr, fmt);
         wr(serial_pkg::serial_mode_control_addr, fmt | 8'h80);
         wr(serial_pkg::serial_mode_control_addr, fmt | 8'he0);
         txf = frame(tx_data[m], m, ~m[0], m[1], 1'b0, nt);
         rxf = frame(~tx_data[m], m, ~m[0], 1'b0, 1'b1, nr);
         fork
            wr(serial_pkg::transmit_shift_addr, tx_data[m]);
            peer.grab(nt, 16, got);
            peer.send(rxf, nr, 16);
         join
         repeat (4) @(posedge clk_sys);
         chk(got, txf);
         chk(12'(n_done), 12'(m + 1));
         rdc(serial_pkg::receive_error_addr, {5'h00, m > 1, 2'b00});
         rdc(serial_pkg::receive_buffer_addr, ~tx_data[m], m[0] ? 8'h7f : 8'hff);
         wr(serial_pkg::serial_mode_control_addr, fmt | 8'h80);
      end
      wr(serial_pkg::serial_mode_control_addr, 8'h81);
      wr(serial_pkg::serial_mode_control_addr, 8'h01);
      rdc(serial_pkg::receive_buffer_addr, 8'hff);
      rdc(serial_pkg::receive_error_addr, 8'h00);
      chk({11'h000, pin_out[0]}, 12'h001);
      wrap_up();
   end
endmodule : async_serial_mode_parity_tb
`default_nettype wire
